// ===== src/dcc_defs.vh
/*
 Constants for the head-end channel-change controller: initialization
 technique codes, message codes, timer figures and state codes.
 Assumes a 125 MHz reference clock; timer counts derive from it.
*/
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// ********************************************************************
// Clock and timing
// ********************************************************************
`define DCC_CLK_HZ 125000000
`define DCC_T13_MS 1000
`define DCC_T15_MIN_MS 4000
`define DCC_T15_MAX_MS 35000
`define DCC_JUMP_DEF_MS 1300
`define DCC_RNG_INIT_MS 30000
`define DCC_RNG_PROC_MS 40
`define DCC_CYC_PER_MS (`DCC_CLK_HZ / 1000)

// ********************************************************************
// Initialization techniques (field in the request)
// ********************************************************************
`define DCC_TECH_REINIT 3'h0
`define DCC_TECH_BCAST 3'h1
`define DCC_TECH_UNICAST 3'h2
`define DCC_TECH_DIRECT 3'h3
`define DCC_TECH_ABSENT 3'h7

// ********************************************************************
// Message codes on the message port
// ********************************************************************
`define DCC_MSG_REQ 2'h1
`define DCC_MSG_RNG_ABORT 2'h2

// ********************************************************************
// Controller states
// ********************************************************************
`define DCC_ST_IDLE 3'h0
`define DCC_ST_SEND 3'h1
`define DCC_ST_HOLD 3'h2
`define DCC_ST_DONE 3'h3
`define DCC_ST_FAIL 3'h4

`endif

// ===== src/dcc_timebase.v
/*
 Free-running millisecond time base for the controller.
 Assumes a synchronous clock enable that freezes it when low.
*/
`default_nettype none

module dcc_timebase #(
	parameter integer CYC_PER_MS = 125000,
	parameter integer W = 32
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire nrst_i,
	input wire en_i,
	// Time
	output reg [W-1:0] now_ms_o,
	output reg tick_o
);
	reg [31:0] pre;

	// Prescaler to one tick per millisecond
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre <= 32'h0;
			now_ms_o <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (en_i) begin
			tick_o <= 1'b0;
			if (pre == CYC_PER_MS - 1) begin
				pre <= 32'h0;
				now_ms_o <= now_ms_o + 1'b1;
				tick_o <= 1'b1;
			end else begin
				pre <= pre + 32'h1;
			end
		end
	end
endmodule // dcc_timebase

`default_nettype wire

// ===== src/dcc_hold_timer.v
/*
 One resource-hold timer: counts down in milliseconds from a load.
 Assumes tick_i is a one-cycle millisecond strobe from the time base.
*/
`default_nettype none

module dcc_hold_timer #(
	parameter integer W = 32
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire nrst_i,
	input wire en_i,
	// Control
	input wire tick_i,
	input wire load_i,
	input wire [W-1:0] load_ms_i,
	input wire stop_i,
	// Status
	output reg running_o,
	output reg expired_o
);
	reg [W-1:0] left;

	// Load wins over stop so a fresh request always restarts the hold
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			left <= {W{1'b0}};
			running_o <= 1'b0;
			expired_o <= 1'b0;
		end else if (en_i) begin
			expired_o <= 1'b0;
			if (load_i) begin
				left <= load_ms_i;
				running_o <= 1'b1;
			end else if (stop_i) begin
				running_o <= 1'b0;
			end else if (running_o && tick_i) begin
				if (left <= 1) begin
					running_o <= 1'b0;
					expired_o <= 1'b1;
				end else begin
					left <= left - 1'b1;
				end
			end
		end
	end
endmodule // dcc_hold_timer

`default_nettype wire

// ===== src/dcc_host_ctrl.v
/*
 Head-end controller for a dynamic channel change. It issues the
 change request to a registered modem, then holds old-channel and
 new-channel resources under two hold timers, reacting to depart,
 arrive, presence and re-init indications from the receive path.
 Assumes all inputs are synchronous to ref_clk_i and that the MAC
 message path turns request strobes into frames.
*/
// Operation
// - Head end may request a change any time after registration.
// - Changes may target the same or a different MAC domain.
// - Every initialization technique can be requested.
// - Management-started and internal changes are both accepted.
// - With re-init, head end never waits for a new-channel response.
// - Depart response never releases old-channel resources.
// - New-channel resources usable without waiting for arrive.
// - Old resources held T13 after last request or until presence.
// - New resources held T15 after last request or depart unless modem seen.
// - Re-init technique reserves nothing new and runs no T15.
// - Non-zero technique: re-init seen may free new resources early.
// - T15 computed from technique and local configuration, bounded.
// - Late initial-ranging arrival on removed resources gets ranging abort.
// - Cross-subnet moves should use a connectivity-safe technique; the commanded technique is passed on unchecked.
// - Old and new upstream channel identifiers should differ.
// - T15 lies between four and 35 seconds.
// - No jump time reported means assume 1.3 seconds.
`default_nettype none
`include "dcc_defs.vh"

module dcc_host_ctrl #(
	parameter integer TW = 32,
	parameter integer CYC_PER_MS = `DCC_CYC_PER_MS,
	parameter integer T13_MS = `DCC_T13_MS,
	parameter integer T15_MIN_MS = `DCC_T15_MIN_MS,
	parameter integer T15_MAX_MS = `DCC_T15_MAX_MS,
	parameter integer JUMP_DEF_MS = `DCC_JUMP_DEF_MS,
	parameter integer RNG_INIT_MS = `DCC_RNG_INIT_MS,
	parameter integer RNG_PROC_MS = `DCC_RNG_PROC_MS,
	parameter integer UCID_W = 8
) (
	// Clock, reset and enable
	input wire ref_clk_i,
	input wire nrst_i,
	input wire clk_en_i,
	// Change command (internal or management)
	input wire cm_registered_i,
	input wire cmd_valid_i,
	input wire cmd_mgmt_i,
	input wire cmd_change_us_i,
	input wire cmd_change_ds_i,
	input wire cmd_inter_domain_i,
	input wire [2:0] cmd_tech_i,
	input wire [UCID_W-1:0] cmd_old_ucid_i,
	input wire [UCID_W-1:0] cmd_new_ucid_i,
	input wire [TW-1:0] unicast_rng_period_ms_i,
	output reg cmd_ready_o,
	// Message transmit strobes
	output reg msg_valid_o,
	output reg [1:0] msg_code_o,
	output reg [2:0] msg_tech_o,
	output reg msg_change_us_o,
	output reg msg_change_ds_o,
	output reg msg_inter_domain_o,
	output reg [UCID_W-1:0] msg_ucid_o,
	// Indications from the receive path
	input wire rsp_depart_i,
	input wire rsp_jump_valid_i,
	input wire [TW-1:0] rsp_jump_ms_i,
	input wire rsp_arrive_i,
	input wire cm_present_new_i,
	input wire cm_reinit_seen_i,
	input wire cm_use_removed_i,
	// Resource holds and status
	output reg hold_old_o,
	output reg hold_new_o,
	output reg [TW-1:0] req_stamp_o,
	output reg [2:0] state_o,
	output reg done_o,
	output reg fail_o
);
	// ****************************************************************
	// Time base and hold timers
	// ****************************************************************
	wire tick;
	wire [TW-1:0] now_ms;
	wire t13_run;
	wire t13_exp;
	wire t15_run;
	wire t15_exp;
	reg t13_load;
	reg t15_load;
	reg t13_stop;
	reg t15_stop;
	reg [TW-1:0] t15_ms;

	dcc_timebase #(.CYC_PER_MS(CYC_PER_MS), .W(TW)) u_tb (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.en_i(clk_en_i),
		.now_ms_o(now_ms),
		.tick_o(tick)
	);

	dcc_hold_timer #(.W(TW)) u_t13 (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.en_i(clk_en_i),
		.tick_i(tick),
		.load_i(t13_load),
		.load_ms_i(T13_MS[TW-1:0]),
		.stop_i(t13_stop),
		.running_o(t13_run),
		.expired_o(t13_exp)
	);

	dcc_hold_timer #(.W(TW)) u_t15 (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.en_i(clk_en_i),
		.tick_i(tick),
		.load_i(t15_load),
		.load_ms_i(t15_ms),
		.stop_i(t15_stop),
		.running_o(t15_run),
		.expired_o(t15_exp)
	);

	// ****************************************************************
	// Controller state
	// ****************************************************************
	reg [2:0] state;
	reg [2:0] tech;
	reg [TW-1:0] jump_ms;
	reg reinit_mode;
	reg new_removed;
	reg [TW-1:0] rng_ms;
	reg [TW-1:0] t15_raw;
	reg [TW-1:0] jump_eff;

	// A jump time reported with this depart counts at once, not one load late
	always @* begin
		if (state == `DCC_ST_HOLD && rsp_depart_i && rsp_jump_valid_i)
			jump_eff = rsp_jump_ms_i;
		else
			jump_eff = jump_ms;
	end

	// Ranging share of T15 per technique
	always @* begin
		case (tech)
			`DCC_TECH_BCAST: rng_ms = RNG_INIT_MS[TW-1:0];
			`DCC_TECH_UNICAST,
			`DCC_TECH_DIRECT: rng_ms = (unicast_rng_period_ms_i << 1) + RNG_PROC_MS[TW-1:0];
			default: rng_ms = {TW{1'b0}};
		endcase
	end

	// T15 = jump time plus ranging time, clamped to policy limits
	always @* begin
		t15_raw = jump_eff + rng_ms;
		if (t15_raw < T15_MIN_MS[TW-1:0])
			t15_raw = T15_MIN_MS[TW-1:0];
		else if (t15_raw > T15_MAX_MS[TW-1:0])
			t15_raw = T15_MAX_MS[TW-1:0];
		t15_ms = t15_raw;
	end

	// Timer controls, decoded from state and indications
	always @* begin
		t13_load = 1'b0;
		t15_load = 1'b0;
		t13_stop = 1'b0;
		t15_stop = 1'b0;
		if (state == `DCC_ST_SEND) begin
			t13_load = 1'b1;
			t15_load = !reinit_mode;
		end else if (state == `DCC_ST_HOLD) begin
			// Depart alone never stops the old hold
			t13_stop = cm_present_new_i;
			t15_stop = cm_present_new_i || cm_reinit_seen_i;
			// Later jump time restarts T15 from new estimate
			t15_load = rsp_depart_i && !reinit_mode && !cm_present_new_i;
		end
	end

	// Main sequencer: take command, send request, hold, finish
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= `DCC_ST_IDLE;
			tech <= `DCC_TECH_REINIT;
			jump_ms <= {TW{1'b0}};
			reinit_mode <= 1'b0;
			new_removed <= 1'b0;
			cmd_ready_o <= 1'b0;
			msg_valid_o <= 1'b0;
			msg_code_o <= 2'h0;
			msg_tech_o <= 3'h0;
			msg_change_us_o <= 1'b0;
			msg_change_ds_o <= 1'b0;
			msg_inter_domain_o <= 1'b0;
			msg_ucid_o <= {UCID_W{1'b0}};
			hold_old_o <= 1'b0;
			hold_new_o <= 1'b0;
			req_stamp_o <= {TW{1'b0}};
			state_o <= `DCC_ST_IDLE;
			done_o <= 1'b0;
			fail_o <= 1'b0;
		end else if (clk_en_i) begin
			msg_valid_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			case (state)
				`DCC_ST_IDLE: begin
					// Only registered modems may be moved
					cmd_ready_o <= cm_registered_i;
					// Removed-resource mark survives a timed-out move so a late arrival can be aborted
					// Internal and management commands share one path
					if (cmd_valid_i && cmd_ready_o && cm_registered_i &&
					    (cmd_change_us_i || cmd_change_ds_i)) begin
						cmd_ready_o <= 1'b0;
						new_removed <= 1'b0;
						tech <= cmd_tech_i;
						// Absent field makes the modem re-init
						reinit_mode <= (cmd_tech_i == `DCC_TECH_REINIT) ||
						               (cmd_tech_i == `DCC_TECH_ABSENT);
						jump_ms <= JUMP_DEF_MS[TW-1:0];
						msg_change_us_o <= cmd_change_us_i;
						msg_change_ds_o <= cmd_change_ds_i;
						msg_inter_domain_o <= cmd_inter_domain_i;
						msg_tech_o <= cmd_tech_i; // Commanded choice kept, inter-domain not checked
						// Commanded upstream id when it differs from the old one, else bumped by one
						msg_ucid_o <= (cmd_new_ucid_i != cmd_old_ucid_i) ? cmd_new_ucid_i :
						              cmd_new_ucid_i + 1'b1;
						state <= `DCC_ST_SEND;
					end else if (cm_use_removed_i && new_removed && tech == `DCC_TECH_BCAST) begin
						// Late initial-ranging arrival after the hold lapsed still gets an abort
						cmd_ready_o <= 1'b0;
						new_removed <= 1'b0;
						msg_valid_o <= 1'b1;
						msg_code_o <= `DCC_MSG_RNG_ABORT;
						state <= `DCC_ST_FAIL;
					end
				end
				`DCC_ST_SEND: begin
					// Request goes out; timers start on this cycle
					msg_valid_o <= 1'b1;
					msg_code_o <= `DCC_MSG_REQ;
					req_stamp_o <= now_ms;
					hold_old_o <= 1'b1;
					// New resources usable at once, no arrive needed
					hold_new_o <= !reinit_mode;
					state <= `DCC_ST_HOLD;
				end
				`DCC_ST_HOLD: begin
					// Reported jump time replaces the default
					if (rsp_depart_i && rsp_jump_valid_i)
						jump_ms <= rsp_jump_ms_i;
					// Old side freed by presence or T13 here, by arrive below
					if (cm_present_new_i || t13_exp)
						hold_old_o <= 1'b0;
					// New side freed by re-init or T15, unless presence seen
					if (!cm_present_new_i && (cm_reinit_seen_i || t15_exp)) begin
						hold_new_o <= 1'b0;
						new_removed <= !reinit_mode;
					end
					// Late initial-ranging arrival gets an abort
					if (cm_use_removed_i && new_removed && tech == `DCC_TECH_BCAST) begin
						msg_valid_o <= 1'b1;
						msg_code_o <= `DCC_MSG_RNG_ABORT;
						state <= `DCC_ST_FAIL;
					end else if (cm_present_new_i || rsp_arrive_i) begin
						// Presence or arrive: old side freed, change done
						hold_old_o <= 1'b0;
						state <= `DCC_ST_DONE;
					end else if (!t13_run && !t15_run && !t13_load && !t15_load &&
					             !hold_new_o && (reinit_mode || new_removed)) begin
						hold_old_o <= 1'b0;
						state <= reinit_mode ? `DCC_ST_DONE : `DCC_ST_FAIL;
					end
				end
				`DCC_ST_DONE: begin
					// With re-init the new holder releases nothing here
					hold_new_o <= 1'b0;
					new_removed <= 1'b0;
					done_o <= 1'b1;
					state <= `DCC_ST_IDLE;
				end
				`DCC_ST_FAIL: begin
					hold_old_o <= 1'b0;
					hold_new_o <= 1'b0;
					fail_o <= 1'b1;
					state <= `DCC_ST_IDLE;
				end
				default: state <= `DCC_ST_IDLE;
			endcase
			state_o <= state;
		end
	end
endmodule // dcc_host_ctrl

`default_nettype wire

// ===== verification/dcc_host_ctrl_properties.sv
/*
 Checker for the channel-change controller: request timing and resource holds.
 Assumes it is bound onto dcc_host_ctrl with that module's parameters.
*/
`default_nettype none
`include "dcc_defs.vh"

module dcc_host_ctrl_properties #(
	parameter integer TW = 32,
	parameter integer UCID_W = 8,
	parameter integer CYC_PER_MS = 125000,
	parameter integer T13_MS = 1000,
	parameter integer T15_MIN_MS = 4000,
	parameter integer T15_MAX_MS = 35000
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	// Command
	input wire logic cm_registered_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_change_us_i,
	input wire logic cmd_change_ds_i,
	input wire logic [2:0] cmd_tech_i,
	input wire logic [UCID_W-1:0] cmd_old_ucid_i,
	input wire logic cmd_ready_o,
	// Message
	input wire logic msg_valid_o,
	input wire logic [1:0] msg_code_o,
	input wire logic [2:0] msg_tech_o,
	input wire logic [UCID_W-1:0] msg_ucid_o,
	// Indications and holds
	input wire logic rsp_depart_i,
	input wire logic cm_present_new_i,
	input wire logic cm_reinit_seen_i,
	input wire logic hold_old_o,
	input wire logic hold_new_o,
	input wire logic [TW-1:0] req_stamp_o,
	input wire logic done_o,
	input wire logic fail_o
);
	// ************************************************************
	// Cycles since the last request and since the last request or depart
	// ************************************************************
	logic [15:0] since;
	logic [15:0] dsince;
	wire logic take = clk_en_i && cmd_valid_i && cmd_ready_o && cm_registered_i && (cmd_change_us_i || cmd_change_ds_i);
	wire logic req = msg_valid_o && (msg_code_o == `DCC_MSG_REQ);
	wire logic reinit = (msg_tech_o == `DCC_TECH_REINIT) || (msg_tech_o == `DCC_TECH_ABSENT);

	// Saturating, so a long idle never wraps into a false pass
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			since <= 16'h0;
			dsince <= 16'h0;
		end else begin
			since <= req ? 16'h0 : since + {15'h0, since != 16'hFFFF};
			dsince <= (req || rsp_depart_i) ? 16'h0 : dsince + {15'h0, dsince != 16'hFFFF};
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	AST_TAKE_TO_REQ: assert property (take |-> ##2 req) else $error("request not sent two cycles after take");
	AST_TECH_COPY: assert property (take |-> ##2 msg_tech_o == $past(cmd_tech_i, 2))
		else $error("technique not carried into request");
	AST_UCID_DIFFER: assert property (take |-> ##2 msg_ucid_o != $past(cmd_old_ucid_i, 2))
		else $error("new channel id equals old one");
	AST_NEW_ON_SEND: assert property (req |-> hold_old_o && (hold_new_o == !reinit))
		else $error("holds wrong at request");
	AST_OLD_HELD: assert property ($fell(hold_old_o) |-> $past(cm_present_new_i) || since >= (T13_MS - 1) * CYC_PER_MS)
		else $error("old hold released early");
	AST_OLD_BOUND: assert property (hold_old_o && !req |-> since <= (T13_MS + 1) * CYC_PER_MS + 4)
		else $error("old hold kept past its interval");
	AST_NEW_HELD: assert property ($fell(hold_new_o) |-> done_o || $past(cm_reinit_seen_i)
		|| since >= (T15_MIN_MS - 1) * CYC_PER_MS) else $error("new hold released early");
	AST_NEW_BOUND: assert property (hold_new_o && !req |-> dsince <= (T15_MAX_MS + 1) * CYC_PER_MS + 4)
		else $error("new hold kept past maximum");
	AST_ABORT_FAILS: assert property (msg_valid_o && msg_code_o == `DCC_MSG_RNG_ABORT
		|-> msg_tech_o == `DCC_TECH_BCAST && !hold_new_o ##[1:4] fail_o) else $error("abort misplaced");
	AST_STAMP_AT_SEND: assert property ($changed(req_stamp_o) |-> req) else $error("stamp moved off request");

	// Main scenarios reached
	COV_TAKE: cover property (take);
	COV_ABORT: cover property (msg_valid_o && msg_code_o == `DCC_MSG_RNG_ABORT);
	COV_DONE_REINIT: cover property (done_o && reinit);
endmodule // dcc_host_ctrl_properties

bind dcc_host_ctrl dcc_host_ctrl_properties #(.TW(TW), .UCID_W(UCID_W), .CYC_PER_MS(CYC_PER_MS), .T13_MS(T13_MS),
	.T15_MIN_MS(T15_MIN_MS), .T15_MAX_MS(T15_MAX_MS)) i_dcc_host_ctrl_properties (.ref_clk_i(ref_clk_i),
	.nrst_i(nrst_i), .clk_en_i(clk_en_i), .cm_registered_i(cm_registered_i), .cmd_valid_i(cmd_valid_i),
	.cmd_change_us_i(cmd_change_us_i), .cmd_change_ds_i(cmd_change_ds_i), .cmd_tech_i(cmd_tech_i),
	.cmd_old_ucid_i(cmd_old_ucid_i), .cmd_ready_o(cmd_ready_o), .msg_valid_o(msg_valid_o), .msg_code_o(msg_code_o),
	.msg_tech_o(msg_tech_o), .msg_ucid_o(msg_ucid_o), .rsp_depart_i(rsp_depart_i), .cm_present_new_i(cm_present_new_i),
	.cm_reinit_seen_i(cm_reinit_seen_i), .hold_old_o(hold_old_o), .hold_new_o(hold_new_o), .req_stamp_o(req_stamp_o),
	.done_o(done_o), .fail_o(fail_o));
`default_nettype wire

// ===== verification/dcc_modem_model.sv
/*
 Behavioural modem answering channel-change requests from the head end.
 Assumes requests arrive as one-cycle strobes synchronous to ref_clk_i.
*/
`default_nettype none
`include "dcc_defs.vh"

module dcc_modem_model (
	// Clock and behaviour: 0 prompt, 1 departs then silent, 2 as 1 with a jump time, 3 late on removed resources
	input wire logic ref_clk_i,
	input wire logic [1:0] mode_i,
	// Request
	input wire logic msg_valid_i,
	input wire logic [1:0] msg_code_i,
	input wire logic [2:0] msg_tech_i,
	// Indications
	output logic depart_o,
	output logic jump_valid_o,
	output logic [31:0] jump_ms_o,
	output logic arrive_o,
	output logic present_o,
	output logic reinit_o,
	output logic use_removed_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] tech;

	// One-cycle indication, launched just after an edge
	task automatic pulse(input int k);
		#1;
		case (k)
			0: begin
				{depart_o, jump_valid_o} = {1'b1, mode_i == 2'h2};
				jump_ms_o = (mode_i == 2'h2) ? 32'h0000_0014 : 32'hFFFF_FFFF;
			end
			1: {present_o, arrive_o} = 2'h3;
			default: use_removed_o = 1'b1;
		endcase
		@(posedge ref_clk_i);
		#1 {depart_o, jump_valid_o, present_o, arrive_o, use_removed_o} = 5'h00;
	endtask

	// Jump time reported only in mode 2; the junk value shows if valid is ignored
	initial begin
		{depart_o, jump_valid_o, arrive_o, present_o, reinit_o, use_removed_o} = 6'h0;
		jump_ms_o = 32'hFFFF_FFFF;
		forever begin
			@(posedge ref_clk_i);
			#1;
			if (msg_valid_i === 1'b1 && msg_code_i === `DCC_MSG_REQ) begin
				tech = msg_tech_i;
				if (mode_i == 2'h3) begin
					repeat (334) @(posedge ref_clk_i);
					pulse(2);
				end else begin
					// Old channel used a little longer, then left well inside T13
					repeat (4) @(posedge ref_clk_i);
					pulse(0);
					// Re-init when told or field absent, and then no answer on new channel
					if (mode_i == 2'h0 && tech != `DCC_TECH_REINIT && tech != `DCC_TECH_ABSENT) begin
						repeat (5) @(posedge ref_clk_i);
						// New channel in use: presence and arrive raised in the same cycle
						pulse(1);
					end
				end
			end
		end
	end
endmodule // dcc_modem_model
`default_nettype wire

// ===== verification/dcc_host_ctrl_tb_top.sv
/*
 Self-checking bench for the head-end channel-change controller.
 Assumes the behavioural modem model and the bound checker.
*/
`default_nettype none
`include "dcc_defs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %0h want %0h", $time, a, b); end end

module dcc_host_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1, cm_registered_i = 1'b0, cmd_valid_i = 1'b0;
	logic cmd_mgmt_i = 1'b0, cmd_change_us_i = 1'b0, cmd_change_ds_i = 1'b0, cmd_inter_domain_i = 1'b0;
	logic [2:0] cmd_tech_i = 3'h0;
	logic [7:0] cmd_old_ucid_i = 8'h01, cmd_new_ucid_i = 8'h02;
	logic [31:0] unicast_rng_period_ms_i = 32'h3;
	logic [1:0] mode = 2'h0;
	logic cmd_ready_o, msg_valid_o, msg_change_us_o, msg_change_ds_o, msg_inter_domain_o, hold_old_o, hold_new_o;
	logic done_o, fail_o, rsp_depart_i, rsp_jump_valid_i, rsp_arrive_i, cm_present_new_i, cm_reinit_seen_i;
	logic cm_use_removed_i;
	logic [1:0] msg_code_o;
	logic [2:0] msg_tech_o, state_o;
	logic [7:0] msg_ucid_o;
	logic [31:0] req_stamp_o, rsp_jump_ms_i;
	int err_total = 0, checked = 0;

	// Short millisecond so every hold fits in a brief run
	dcc_host_ctrl #(.CYC_PER_MS(10), .T13_MS(3), .T15_MIN_MS(8), .T15_MAX_MS(40), .JUMP_DEF_MS(2), .RNG_INIT_MS(30),
		.RNG_PROC_MS(4)) i_dcc_host_ctrl (.*);
	dcc_modem_model i_dcc_modem_model (.ref_clk_i(ref_clk_i), .mode_i(mode), .msg_valid_i(msg_valid_o),
		.msg_code_i(msg_code_o), .msg_tech_i(msg_tech_o), .depart_o(rsp_depart_i), .jump_valid_o(rsp_jump_valid_i),
		.jump_ms_o(rsp_jump_ms_i), .arrive_o(rsp_arrive_i), .present_o(cm_present_new_i),
		.reinit_o(cm_reinit_seen_i), .use_removed_o(cm_use_removed_i));

	initial forever #4 ref_clk_i = ~ref_clk_i;

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Offers one command and checks the request that follows
	task automatic send(input logic [2:0] tech, input logic [1:0] md, input logic [7:0] oldu);
		int n = 0;
		mode = md;
		{cmd_tech_i, cmd_old_ucid_i, cmd_mgmt_i, cmd_inter_domain_i} = {tech, oldu, tech[1], tech[0]};
		// Equal ids only with the field absent, so the bump is seen once
		cmd_new_ucid_i = (tech == `DCC_TECH_ABSENT) ? oldu : oldu + 8'h10;
		{cmd_change_us_i, cmd_change_ds_i, cmd_valid_i} = {1'b1, tech[0], 1'b1};
		while (cmd_ready_o !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		tick(1);
		cmd_valid_i = 1'b0;
		// Request strobe stands only in the cycle after the send state
		tick(1);
		`CHK(msg_valid_o, 1'b1)
		`CHK(msg_change_us_o, 1'b1)
		`CHK(msg_change_ds_o, tech[0])
		`CHK(msg_code_o, `DCC_MSG_REQ)
		`CHK(msg_tech_o, tech)
		`CHK(msg_inter_domain_o, tech[0])
		`CHK(msg_ucid_o, (tech == `DCC_TECH_ABSENT) ? oldu + 8'h01 : oldu + 8'h10)
		`CHK(hold_old_o, 1'b1)
		`CHK(hold_new_o, tech != `DCC_TECH_REINIT && tech != `DCC_TECH_ABSENT)
	endtask

	// Waits for the end of the transaction and checks how and when it ended
	task automatic finish(input logic ok, input int lo, input int hi);
		int n = 0;
		while (done_o !== 1'b1 && fail_o !== 1'b1 && n < 600) begin
			tick(1);
			n++;
		end
		`CHK(done_o, ok)
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask

	// Unregistered modem, a command that moves nothing, a frozen clock enable: all ignored
	task automatic refuse(input logic regd, input logic us, input logic en);
		{cm_registered_i, cmd_change_us_i, cmd_change_ds_i, cmd_valid_i, clk_en_i} = {regd, us, 2'h1, en};
		tick(10);
		{cmd_valid_i, clk_en_i} = 2'h1;
		`CHK(state_o, `DCC_ST_IDLE)
		`CHK(hold_old_o, 1'b0)
		`CHK(msg_valid_o, 1'b0)
		tick(1);
	endtask

	initial begin
		logic [2:0] techs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		int n = 0;
		tick(8);
		nrst_i = 1'b1;
		tick(1);
		refuse(1'b0, 1'b1, 1'b1);
		refuse(1'b1, 1'b0, 1'b1);
		refuse(1'b1, 1'b1, 1'b0);
		// Every technique answered promptly; the last one with equal channel ids
		for (int k = 0; k < 5; k++) begin
			send(techs[k], 2'h0, (k == 4) ? 8'h02 : 8'h01);
			if (k == 0 || k == 4)
				finish(1'b1, 18, 45);
			else
				finish(1'b1, 5, 25);
		end
		// Modem departs and goes silent: old hold kept past the depart
		send(`DCC_TECH_UNICAST, 2'h1, 8'h05);
		tick(8);
		`CHK(hold_old_o, 1'b1)
		finish(1'b0, 100, 140);
		// Depart with a reported jump time: the new hold runs from that figure
		send(`DCC_TECH_DIRECT, 2'h2, 8'h05);
		finish(1'b0, 290, 320);
		// Late first use after the new hold lapsed
		send(`DCC_TECH_BCAST, 2'h3, 8'h05);
		while (!(msg_valid_o === 1'b1 && msg_code_o === `DCC_MSG_RNG_ABORT) && n < 500) begin
			tick(1);
			n++;
		end
		`CHK(n < 500, 1'b1)
		finish(1'b0, 0, 10);
		report_and_stop();
	end

	// Whole run is about a thousand cycles; this is far beyond it
	initial begin
		#100us;
		err_total++;
		report_and_stop();
	end
endmodule // dcc_host_ctrl_tb_top
`default_nettype wire
